// >>> hw/pts_div.sv
// Serial signed divider producing a fixed-point quotient.
// Assumes operands are held stable from start until done.
module pts_div (
    input wire logic i_clk,                          // Core clock
    input wire logic i_rst_n,                        // Synchronised reset, active low
    input wire logic i_start,                        // Pulse to begin
    input wire logic signed [pts_pkg::TS_W-1:0] i_num, // Numerator
    input wire logic signed [pts_pkg::TS_W-1:0] i_den, // Denominator
    output logic o_done,                             // One-cycle completion pulse
    output logic signed [pts_pkg::TS_W-1:0] o_quot   // Quotient, fraction bits per package
);
    import pts_pkg::*;
    localparam int W = TS_W + DRIFT_FRAC;
    logic [W-1:0] rem_q, rem_d;           // Partial remainder
    logic [W-1:0] num_q, num_d;           // Shifting numerator
    logic [W-1:0] quo_q, quo_d;           // Growing quotient
    logic [6:0] cnt_q, cnt_d;             // Steps left
    logic neg_q, neg_d;                   // Result sign
    logic busy_q, busy_d;                 // Running
    logic done_q, done_d;                 // Completion pulse
    logic [TS_W-1:0] den_abs;             // Magnitude of divisor
    logic [W-1:0] trial;                  // Remainder after shift

    assign den_abs = i_den[TS_W-1] ? TS_W'(-i_den) : TS_W'(i_den);

    // Restoring division, one bit per cycle; slow but tiny
    always_comb begin
        rem_d = rem_q;
        num_d = num_q;
        quo_d = quo_q;
        cnt_d = cnt_q;
        neg_d = neg_q;
        busy_d = busy_q;
        done_d = 1'b0;
        trial = {rem_q[W-2:0], num_q[W-1]};
        if (i_start) begin
            // Numerator scaled up by the fraction bits
            rem_d = '0;
            num_d = {(i_num[TS_W-1] ? TS_W'(-i_num) : TS_W'(i_num)), DRIFT_FRAC'(0)};
            quo_d = '0;
            cnt_d = 7'(DIV_STEPS);
            neg_d = i_num[TS_W-1] ^ i_den[TS_W-1];
            busy_d = 1'b1;
        end else if (busy_q) begin
            num_d = {num_q[W-2:0], 1'b0};
            if (trial >= W'(den_abs)) begin
                rem_d = trial - W'(den_abs);
                quo_d = {quo_q[W-2:0], 1'b1};
            end else begin
                rem_d = trial;
                quo_d = {quo_q[W-2:0], 1'b0};
            end
            cnt_d = cnt_q - 7'h01;
            if (cnt_q == 7'h01) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    // State registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rem_q <= '0;
            num_q <= '0;
            quo_q <= '0;
            cnt_q <= 7'h00;
            neg_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            rem_q <= rem_d;
            num_q <= num_d;
            quo_q <= quo_d;
            cnt_q <= cnt_d;
            neg_q <= neg_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;
    assign o_quot = neg_q ? TS_W'(-quo_q[TS_W-1:0]) : quo_q[TS_W-1:0];
endmodule // pts_div

// >>> hw/pts_pkg.sv
// Constants, carriers and helpers for the two-step slave time sync block.
// Assumes a message parser upstream that delivers decoded PTP fields as one-cycle strobes.
package pts_pkg;
    localparam int TS_W = 64;                  // Timestamp width, signed nanoseconds
    localparam int CORR_W = 64;                // Correction field width
    localparam int DRIFT_FRAC = 32;            // Fraction bits of the drift ratio
    localparam int CLK_HZ = 20_000_000;        // Core clock rate
    localparam int SYNC_TIMEOUT_S = 1;         // Longest allowed gap between Syncs
    localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_S * CLK_HZ; // Cycles, rounded down
    localparam int DIV_STEPS = TS_W + DRIFT_FRAC; // Iterations of the serial divider

    // Codes of the decoded message kinds
    typedef enum logic [2:0] {
        PTS_MSG_SYNC = 3'h0,
        PTS_MSG_FOLLOW = 3'h1,
        PTS_MSG_DREQ = 3'h2,
        PTS_MSG_DRESP = 3'h3,
        PTS_MSG_OTHER = 3'h4
    } pts_msg_type;

    // One parsed message from the port
    typedef struct packed {
        pts_msg_type kind;                     // Message kind
        logic two_step;                        // Two-step flag from the header
        logic signed [CORR_W-1:0] corr;        // Correction field, ns
        logic signed [TS_W-1:0] ts;            // Carried origin/receive timestamp
        logic signed [TS_W-1:0] hw_ts;         // Local hardware timestamp of the event
    } pts_msg_type_s_type;

    // Computed results
    typedef struct packed {
        logic signed [TS_W-1:0] delay;         // Mean path delay
        logic signed [TS_W-1:0] offset;        // Slave minus master
        logic signed [TS_W-1:0] drift;         // Ratio, DRIFT_FRAC fraction bits
    } pts_result_type;

    // Signed arithmetic right shift by one (halving)
    function automatic logic signed [TS_W-1:0] pts_half(input logic signed [TS_W:0] v);
        pts_half = v[TS_W:1];
    endfunction
endpackage

// >>> hw/pts_slave_sync.sv
// Two-step end-to-end PTP slave: timestamp collection and delay/offset/drift computation.
// Assumes an upstream parser that strobes each decoded message with its hardware timestamp.
module pts_slave_sync (
    input wire logic i_core_clk,                      // 20 MHz core clock
    input wire logic i_nrst,                          // Async reset, active low
    input wire logic i_msg_vld,                       // Parsed message strobe
    input wire pts_pkg::pts_msg_type_s_type i_msg,    // Parsed message fields
    input wire logic i_dreq_sent,                     // Delay request left the port
    input wire logic signed [pts_pkg::TS_W-1:0] i_dreq_ts, // Its hardware transmit time
    input wire logic i_is_slave,                      // Best-master selection says slave
    output logic o_dreq_go,                           // Pulse: send a delay request
    output logic o_res_vld,                           // Pulse: new delay and offset
    output pts_pkg::pts_result_type o_res,            // Results
    output logic o_drift_vld,                         // Pulse: new drift
    output logic o_unsup,                             // Sticky: unsupported form seen
    output logic o_sync_lost                          // Level: Sync gap too long
);
    import pts_pkg::*;

    // Exchange progress, Gray-coded from idle through to calc; the return to idle flips two bits
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FOLLOW = 3'b001,
        ST_SEND = 3'b011,
        ST_DRESP = 3'b010,
        ST_CALC = 3'b110
    } pts_state_type;

    logic rst_s1_q, rst_s2_q;                         // Reset release synchroniser
    logic rst_n;                                      // Synchronised reset
    pts_state_type st_q, st_d;                        // Exchange state
    logic signed [TS_W-1:0] t1_q, t1_d;               // Master Sync transmit time
    logic signed [TS_W-1:0] t2_q, t2_d;               // Local Sync receive time
    logic signed [TS_W-1:0] t3_q, t3_d;               // Local delay request transmit
    logic signed [TS_W-1:0] t4_q, t4_d;               // Master delay request receive
    logic signed [CORR_W-1:0] cms_q, cms_d;           // Sync plus follow-up correction
    logic signed [CORR_W-1:0] csm_q, csm_d;           // Delay response correction
    logic signed [TS_W-1:0] pt1_q, pt1_d;             // Previous t1
    logic signed [TS_W-1:0] pt2_q, pt2_d;             // Previous t2
    logic have_prev_q, have_prev_d;                   // A previous pair exists
    logic go_q, go_d;                                 // Delay request pulse
    logic rv_q, rv_d;                                 // Result pulse
    pts_result_type res_q, res_d;                     // Result store
    logic unsup_q, unsup_d;                           // Unsupported form flag
    logic [31:0] gap_q, gap_d;                        // Cycles since last Sync
    logic lost_q, lost_d;                             // Sync timeout flag
    logic div_start_q, div_start_d;                   // Launch drift divide
    logic signed [TS_W-1:0] dm_q, dm_d;               // Master interval
    logic signed [TS_W-1:0] dsd_q, dsd_d;             // Slave minus master interval
    logic div_done;                                   // Divider finished
    logic signed [TS_W-1:0] div_quot;                 // Divider result
    logic signed [TS_W:0] tms;                        // Corrected master-to-slave interval
    logic signed [TS_W:0] tsm;                        // Corrected slave-to-master interval
    logic sync_in, fol_in, resp_in;                   // Message strobes by kind

    // Reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    assign sync_in = i_msg_vld && i_is_slave && i_msg.kind == PTS_MSG_SYNC;
    assign fol_in = i_msg_vld && i_is_slave && i_msg.kind == PTS_MSG_FOLLOW;
    assign resp_in = i_msg_vld && i_is_slave && i_msg.kind == PTS_MSG_DRESP;

    // Signed intervals with corrections removed; one extra bit stops overflow before halving
    assign tms = (TS_W+1)'(t2_q) - (TS_W+1)'(t1_q) - (TS_W+1)'(cms_q);
    assign tsm = (TS_W+1)'(t4_q) - (TS_W+1)'(t3_q) - (TS_W+1)'(csm_q);

    // Exchange sequencer and arithmetic
    always_comb begin
        st_d = st_q;
        t1_d = t1_q;
        t2_d = t2_q;
        t3_d = t3_q;
        t4_d = t4_q;
        cms_d = cms_q;
        csm_d = csm_q;
        pt1_d = pt1_q;
        pt2_d = pt2_q;
        have_prev_d = have_prev_q;
        go_d = 1'b0;
        rv_d = 1'b0;
        res_d = res_q;
        unsup_d = unsup_q;
        div_start_d = 1'b0;
        dm_d = dm_q;
        dsd_d = dsd_q;
        // One-step Sync is outside the supported form; flag and ignore it
        if (sync_in && !i_msg.two_step) begin
            unsup_d = 1'b1;
        end
        // A role change abandons the exchange in flight
        if (!i_is_slave) begin
            st_d = ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    // Hardware receive stamp of the event message is t2
                    if (sync_in && i_msg.two_step) begin
                        t2_d = i_msg.hw_ts;
                        cms_d = i_msg.corr;
                        st_d = ST_FOLLOW;
                    end
                end
                ST_FOLLOW: begin
                    // Precise t1 arrives in the follow-up general message
                    if (fol_in) begin
                        t1_d = i_msg.ts;
                        cms_d = cms_q + i_msg.corr;
                        go_d = 1'b1;
                        st_d = ST_SEND;
                    end else if (sync_in && i_msg.two_step) begin
                        t2_d = i_msg.hw_ts; // Missed follow-up: restart on newer Sync
                        cms_d = i_msg.corr;
                    end
                end
                ST_SEND: begin
                    // Own transmit stamp of the delay request is t3
                    if (i_dreq_sent) begin
                        t3_d = i_dreq_ts;
                        st_d = ST_DRESP;
                    end
                end
                ST_DRESP: begin
                    // Master receive time t4 with residence correction
                    if (resp_in) begin
                        t4_d = i_msg.ts;
                        csm_d = i_msg.corr;
                        st_d = ST_CALC;
                    end else if (sync_in && i_msg.two_step) begin
                        t2_d = i_msg.hw_ts; // Lost response: start over
                        cms_d = i_msg.corr;
                        st_d = ST_FOLLOW;
                    end
                end
                ST_CALC: begin
                    res_d.delay = pts_half(tms + tsm);
                    res_d.offset = pts_half(tms - tsm);
                    rv_d = 1'b1;
                    // Drift from this pair and the previous one
                    if (have_prev_q && t1_q != pt1_q) begin
                        dm_d = t1_q - pt1_q;
                        dsd_d = (t2_q - pt2_q) - (t1_q - pt1_q);
                        div_start_d = 1'b1;
                    end
                    pt1_d = t1_q;
                    pt2_d = t2_q;
                    have_prev_d = 1'b1;
                    st_d = ST_IDLE;
                end
            endcase
        end
        if (div_done) begin
            res_d.drift = div_quot;
        end
    end

    // Sync gap watchdog; the master must send one per second
    always_comb begin
        gap_d = gap_q;
        lost_d = lost_q;
        if (sync_in) begin
            gap_d = 32'h0000_0000;
            lost_d = 1'b0;
        end else if (gap_q >= 32'(SYNC_TIMEOUT_CYC - 1)) begin
            lost_d = 1'b1;
        end else begin
            gap_d = gap_q + 32'h0000_0001;
        end
    end

    // Registers of the sequencer and watchdog
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            t1_q <= '0;
            t2_q <= '0;
            t3_q <= '0;
            t4_q <= '0;
            cms_q <= '0;
            csm_q <= '0;
            pt1_q <= '0;
            pt2_q <= '0;
            have_prev_q <= 1'b0;
            go_q <= 1'b0;
            rv_q <= 1'b0;
            res_q <= '0;
            unsup_q <= 1'b0;
            div_start_q <= 1'b0;
            dm_q <= '0;
            dsd_q <= '0;
            gap_q <= 32'h0000_0000;
            lost_q <= 1'b0;
            o_drift_vld <= 1'b0;
        end else begin
            st_q <= st_d;
            t1_q <= t1_d;
            t2_q <= t2_d;
            t3_q <= t3_d;
            t4_q <= t4_d;
            cms_q <= cms_d;
            csm_q <= csm_d;
            pt1_q <= pt1_d;
            pt2_q <= pt2_d;
            have_prev_q <= have_prev_d;
            go_q <= go_d;
            rv_q <= rv_d;
            res_q <= res_d;
            unsup_q <= unsup_d;
            div_start_q <= div_start_d;
            dm_q <= dm_d;
            dsd_q <= dsd_d;
            gap_q <= gap_d;
            lost_q <= lost_d;
            o_drift_vld <= div_done;
        end
    end

    // Drift ratio divider; a new exchange takes far longer than the divide
    pts_div u_div (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_start(div_start_q),
        .i_num(dsd_q),
        .i_den(dm_q),
        .o_done(div_done),
        .o_quot(div_quot)
    );

    assign o_dreq_go = go_q;
    assign o_res_vld = rv_q;
    assign o_res = res_q;
    assign o_unsup = unsup_q;
    assign o_sync_lost = lost_q;

    // A delay request is launched only right after a follow-up
    property p_dreq_after_follow;
        @(posedge i_core_clk) disable iff (!rst_n)
        o_dreq_go |-> $past(fol_in) && $past(st_q) == ST_FOLLOW;
    endproperty
    a_dreq_after_follow: assert property (p_dreq_after_follow) else $error("request without follow-up");

    // Captured t3 equals the stamp given with the send strobe
    property p_t3_capture;
        @(posedge i_core_clk) disable iff (!rst_n)
        (st_q == ST_SEND && i_dreq_sent && i_is_slave) |=> t3_q == $past(i_dreq_ts);
    endproperty
    a_t3_capture: assert property (p_t3_capture) else $error("t3 not captured");

    // Delay result is the halved sum
    property p_delay;
        @(posedge i_core_clk) disable iff (!rst_n)
        o_res_vld |-> o_res.delay == pts_half(tms + tsm);
    endproperty
    a_delay: assert property (p_delay) else $error("delay wrong");
    // Delay minus offset gives back the slave-to-master leg exactly, whatever the rounding
    property p_offset;
        @(posedge i_core_clk) disable iff (!rst_n)
        o_res_vld |-> (TS_W+1)'(o_res.delay) - (TS_W+1)'(o_res.offset) == tsm;
    endproperty
    a_offset: assert property (p_offset) else $error("offset wrong");
    // One-step Sync sets the unsupported flag next cycle
    property p_unsup;
        @(posedge i_core_clk) disable iff (!rst_n)
        (sync_in && !i_msg.two_step) |=> o_unsup;
    endproperty
    a_unsup: assert property (p_unsup) else $error("one-step not flagged");
    // Leaving slave role returns to idle
    property p_role;
        @(posedge i_core_clk) disable iff (!rst_n)
        !i_is_slave |=> st_q == ST_IDLE;
    endproperty
    a_role: assert property (p_role) else $error("exchange kept without slave role");
    // Drift valid arrives a fixed time after launch
    property p_drift_time;
        @(posedge i_core_clk) disable iff (!rst_n)
        div_start_q |-> ##[96:98] o_drift_vld;
    endproperty
    a_drift_time: assert property (p_drift_time) else $error("drift late");
    // Follow-up correction adds onto the Sync correction before it is removed
    property p_corr;
        @(posedge i_core_clk) disable iff (!rst_n)
        (st_q == ST_FOLLOW && fol_in) |=> cms_q == $past(cms_q) + $past(i_msg.corr);
    endproperty
    a_corr: assert property (p_corr) else $error("correction not accumulated");
    // Sync timeout flag only after the full gap
    property p_lost;
        @(posedge i_core_clk) disable iff (!rst_n)
        $rose(o_sync_lost) |-> gap_q == 32'(SYNC_TIMEOUT_CYC - 1);
    endproperty
    a_lost: assert property (p_lost) else $error("sync loss early");
endmodule // pts_slave_sync

// >>> testbench/pts_gm_model.sv
// Behavioural grandmaster reached through an end-to-end two-step transparent switch.
// Assumes the bench calls run() and that the slave asks for its delay request by a pulse.
module pts_gm_model (
    input wire logic i_core_clk,                          // Core clock
    input wire logic i_dreq_go,                           // Slave asks to send a delay request
    output logic o_msg_vld,                               // Message strobe toward the slave
    output pts_pkg::pts_msg_type_s_type o_msg,            // Parsed message fields
    output logic o_dreq_sent,                             // Delay request left the slave port
    output logic signed [pts_pkg::TS_W-1:0] o_dreq_ts     // Its transmit stamp
);
    timeunit 1ns;
    timeprecision 1ps;
    import pts_pkg::*;

    // Quiet port at time zero
    initial begin
        o_msg_vld = 1'b0;
        o_msg = '0;
        o_dreq_sent = 1'b0;
        o_dreq_ts = '0;
    end

    // Hold one message for a cycle; strobe stays up so back-to-back sends never glitch it
    task automatic send(input pts_msg_type k, input logic two, input logic signed [63:0] c, ts, hw);
        o_msg = '{kind: k, two_step: two, corr: c, ts: ts, hw_ts: hw};
        o_msg_vld = 1'b1;
        @(negedge i_core_clk);
    endtask

    // Drop the strobe; released lines show the inverse, never the old value
    task automatic idle();
        o_msg_vld = 1'b0;
        o_msg = pts_msg_type_s_type'(~o_msg);
    endtask

    // One full exchange; saw tells whether the slave asked for its delay request
    task automatic run(input logic one_step, input logic signed [63:0] t1, t2, t3, t4, cs, cf, cr,
                       output bit saw);
        saw = 1'b0;
        @(negedge i_core_clk);
        send(PTS_MSG_SYNC, !one_step, cs, 64'h0, t2);
        // Passed-through traffic of another kind lands between Sync and follow-up
        send(PTS_MSG_OTHER, 1'b0, 64'h0, 64'h0, 64'h0);
        send(PTS_MSG_FOLLOW, 1'b0, cf, t1, 64'h0);
        idle();
        // Bounded wait for the request; a silent slave simply ends the exchange
        for (int i = 0; i < 20 && !saw; i++) begin
            saw = (i_dreq_go === 1'b1);
            if (!saw) begin
                @(negedge i_core_clk);
            end
        end
        if (saw) begin
            o_dreq_ts = t3;
            o_dreq_sent = 1'b1;
            @(negedge i_core_clk);
            o_dreq_sent = 1'b0;
            o_dreq_ts = ~o_dreq_ts;
            send(PTS_MSG_DRESP, 1'b0, cr, t4, 64'h0);
            idle();
        end
    endtask
endmodule // pts_gm_model

// >>> testbench/pts_slave_sync_tb.sv
// Self-checking bench for the two-step slave sync block, driven at falling clock edges.
// Assumes the grandmaster model in pts_gm_model; no sync-loss timeout run (20M cycles).
module pts_slave_sync_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pts_pkg::*;
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

    logic core_clk, nrst, is_slave, msg_vld, dreq_sent, dreq_go, res_vld, drift_vld, unsup, sync_lost;
    pts_msg_type_s_type msg; // Message toward the slave
    logic signed [TS_W-1:0] dreq_ts; // Delay request stamp
    pts_result_type res; // Results out of the slave
    int err_total = 0; // Mismatches
    int check_count = 0; // Comparisons

    pts_gm_model gm (.i_core_clk(core_clk), .i_dreq_go(dreq_go), .o_msg_vld(msg_vld), .o_msg(msg),
        .o_dreq_sent(dreq_sent), .o_dreq_ts(dreq_ts));
    pts_slave_sync dut (.i_core_clk(core_clk), .i_nrst(nrst), .i_msg_vld(msg_vld), .i_msg(msg),
        .i_dreq_sent(dreq_sent), .i_dreq_ts(dreq_ts), .i_is_slave(is_slave), .o_dreq_go(dreq_go),
        .o_res_vld(res_vld), .o_res(res), .o_drift_vld(drift_vld), .o_unsup(unsup), .o_sync_lost(sync_lost));

    // 20 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Counts, verdict, end of run
    task automatic stop_test();
        $display("Mismatches %0d of %0d comparisons", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watch a pulse at falling edges, where it is settled; 0 = results, 1 = drift
    task automatic watch(input int which, input int lim, output bit seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge core_clk);
            seen = (which == 0) ? (res_vld === 1'b1) : (drift_vld === 1'b1);
        end
    endtask

    // Expect delay and offset worked out from the four stamps and both corrections
    task automatic check_res(input logic signed [64:0] t1, t2, t3, t4, cms, csm);
        logic signed [64:0] ms, sm, d, o;
        bit seen;
        ms = t2 - t1 - cms;
        sm = t4 - t3 - csm;
        d = ms + sm;
        o = ms - sm;
        watch(0, 10, seen);
        `CHK(seen, 1'b1)
        if (!seen) begin
            stop_test();
        end
        `CHK(res.delay, d[64:1])
        `CHK(res.offset, o[64:1])
    endtask

    // First exchange: odd negative offset, corrections on both legs, no drift yet
    task automatic t_basic();
        bit saw, seen;
        gm.run(1'b0, 1000, 1600, 2000, 2671, 30, 20, 10, saw);
        `CHK(saw, 1'b1)
        check_res(1000, 1600, 2000, 2671, 50, 10);
        watch(1, 120, seen);
        `CHK(seen, 1'b0)
        `CHK(unsup, 1'b0)
    endtask

    // Second exchange: drift against the first pair, 32 fraction bits
    task automatic t_drift();
        bit saw, seen;
        longint dm, ds, de;
        dm = 101000 - 1000;
        ds = 101601 - 1600;
        de = ((ds - dm) <<< 32) / dm;
        repeat (100) @(negedge core_clk);
        gm.run(1'b0, 101000, 101601, 102000, 102500, 30, 20, 10, saw);
        check_res(101000, 101601, 102000, 102500, 50, 10);
        watch(1, 150, seen);
        `CHK(seen, 1'b1)
        `CHK(res.drift, 64'(de))
        `CHK(sync_lost, 1'b0)
    endtask

    // One-step Sync is outside the supported form: flagged, no request, no result
    task automatic t_one_step();
        bit saw, seen;
        repeat (100) @(negedge core_clk);
        gm.run(1'b1, 151000, 151600, 152000, 152500, 0, 0, 0, saw);
        `CHK(saw, 1'b0)
        `CHK(unsup, 1'b1)
        watch(0, 10, seen);
        `CHK(seen, 1'b0)
    endtask

    // Not slave: exchange ignored; back to slave, a new exchange completes
    task automatic t_role();
        bit saw, seen;
        repeat (100) @(negedge core_clk);
        is_slave = 1'b0;
        gm.run(1'b0, 161000, 161600, 162000, 162500, 0, 0, 0, saw);
        `CHK(saw, 1'b0)
        watch(0, 10, seen);
        `CHK(seen, 1'b0)
        // Selection hands this port the slave role again
        is_slave = 1'b1;
        repeat (100) @(negedge core_clk);
        gm.run(1'b0, 201000, 201700, 202000, 202300, 0, 5, 0, saw);
        `CHK(saw, 1'b1)
        check_res(201000, 201700, 202000, 202300, 5, 0);
    endtask

    // Hang guard: a run past its budget is a mismatch
    initial begin
        #(60000 * 50);
        err_total++;
        stop_test();
    end

    // Reset for 8 cycles, settle past the internal release, then the scenarios
    initial begin
        nrst = 1'b0;
        is_slave = 1'b1;
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        repeat (5) @(negedge core_clk);
        t_basic();
        t_drift();
        t_one_step();
        t_role();
        stop_test();
    end
endmodule // pts_slave_sync_tb
